// [bxm_mode_ctrl.sv]
// Mode capture and mode-dependent request routing of the bus extension unit.
// Function
// - Sample strap in the first cycle after reset release; record mode in local bus control register.
// - Processor mode enables cache, prefetch and message handling.
// - Pure processor module: local-bus slave only, no arbitration.
// - Processor mode with global memory: local-bus master and slave.
// - Outbound requests win over inbound ones in processor mode.
// - Memory mode: master only, no local requests, inbound only.
// - Memory mode disables cache, prefetch, messages; enables memory support.
// - Buffers: three in, three out in processor; three in, none in memory.
// - Message handling for processors exists only in processor mode.
// - Processor mode marks outbound read-modify-write with the lock signal.
// - Memory mode keeps internal locks making inbound read-modify-write atomic.
// - Dual-function pins take processor or memory meaning by mode.
// - Recognized address: identical access on other bus, or cache service.
// - Addresses pass unaltered; inbound served in arrival order with replies.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module bxm_mode_ctrl (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Strap.
  input wire logic mode_strap_pin,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Local bus slave side, requests toward the system bus.
  input wire logic loc_req_valid,
  input wire bxm_pkg::bxm_req_s loc_req,
  output logic loc_req_ready,
  output logic loc_cache_serve,
  // System packet bus, outbound request.
  output logic sys_out_valid,
  output bxm_pkg::bxm_req_s sys_out,
  output logic sys_lock,
  // System packet bus, inbound request and reply.
  input wire logic sys_req_valid,
  input wire bxm_pkg::bxm_req_s sys_req,
  output logic sys_req_ready,
  output logic sys_rpy_valid,
  output bxm_pkg::bxm_rpy_s sys_rpy,
  // Local bus master side.
  output logic loc_arb_req,
  input wire logic loc_grant,
  output logic loc_mst_valid,
  output bxm_pkg::bxm_req_s loc_mst,
  input wire logic loc_done,
  input wire bxm_pkg::bxm_rpy_s loc_rdata,
  // Message delivery toward processors.
  output logic inter_agent_message,
  output logic [31:0] msg_addr,
  // Memory support status inputs.
  input wire logic [3:0] mem_status,
  // Mode and function enables.
  output logic mode_mem,
  output logic cache_en,
  output logic prefetch_en,
  output logic msg_en,
  output logic mem_sup_en,
  // Dual-function pins.
  output logic [7:0] dual_pins
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ARB = 5'b00010,
    ST_WAIT = 5'b00100,
    ST_RPY = 5'b01000,
    ST_MSG = 5'b10000
  } bxm_state_e;

  bxm_state_e state_r;
  logic cap_done_r;
  logic mode_r;
  logic [bxm_pkg::CTL_W-1:0] ctl_r;
  logic [31:0] match_r;
  logic [31:0] mask_r;
  logic [31:0] reg_rdata_r;
  bxm_pkg::bxm_req_s cur_r;
  bxm_pkg::bxm_rpy_s rpy_r;
  logic rpy_valid_r;
  logic out_valid_r;
  bxm_pkg::bxm_req_s out_r;
  logic lock_r;
  logic cache_serve_r;
  logic arb_r;
  logic mst_valid_r;
  logic msg_r;
  logic [31:0] msg_addr_r;
  logic [4:0] en_r;
  logic [7:0] pins_r;
  logic ready_in_r;
  logic ready_out_r;

  logic out_full;
  logic out_empty;
  logic in_full;
  logic in_empty;
  logic [1:0] out_cnt;
  logic [1:0] in_cnt;
  bxm_pkg::bxm_req_s out_head;
  bxm_pkg::bxm_req_s in_head;
  logic out_pop;
  logic in_pop;
  logic in_push;
  logic lk_held;
  logic lk_block;
  logic lk_set;
  logic lk_clr;
  logic is_mem;
  logic master_ok;

  // Recognizes an address inside the window set by match and mask.
  function automatic logic in_window(input logic [31:0] a, input logic [31:0] m, input logic [31:0] k);
    in_window = ((a ^ m) & k) == 32'h0000_0000;
  endfunction

  // Message space sits at the top of the address range.
  function automatic logic is_msg(input logic [31:0] a);
    is_msg = (a[31:24] == bxm_pkg::MSG_SPACE);
  endfunction

  assign is_mem = (mode_r == bxm_pkg::MODE_MEM);
  // Master role in memory mode, or in processor mode with global memory.
  assign master_ok = is_mem || ctl_r[bxm_pkg::CTL_GMEM];

  // Mode capture in the first cycle after reset release; the strap is
  // never looked at again, so glitches on it later are harmless.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_done_r <= 1'b0;
      mode_r <= bxm_pkg::MODE_RST;
    end
    else if (!cap_done_r)
    begin
      cap_done_r <= 1'b1;
      mode_r <= mode_strap_pin;
    end
  end

  // Register writes; the mode bit is read only.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctl_r <= bxm_pkg::CTL_RST;
      match_r <= bxm_pkg::MATCH_RST;
      mask_r <= bxm_pkg::MASK_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == bxm_pkg::REG_CTRL)
        ctl_r <= {reg_wdata[bxm_pkg::CTL_W-1:1], 1'b0};
      if (reg_addr == bxm_pkg::REG_MATCH)
        match_r <= reg_wdata;
      if (reg_addr == bxm_pkg::REG_MASK)
        mask_r <= reg_wdata;
    end
  end

  // Register reads, data in the following cycle; unmapped reads as zero.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      reg_rdata_r <= 32'h0000_0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        bxm_pkg::REG_CTRL: reg_rdata_r <= {27'h000_0000, ctl_r[bxm_pkg::CTL_W-1:1], mode_r};
        bxm_pkg::REG_STAT: reg_rdata_r <= {26'h000_0000, state_r != ST_IDLE, lk_held, out_cnt, in_cnt};
        bxm_pkg::REG_MATCH: reg_rdata_r <= match_r;
        bxm_pkg::REG_MASK: reg_rdata_r <= mask_r;
        default: reg_rdata_r <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata_r <= 32'h0000_0000;
  end

  // Outbound buffer: no capacity at all in memory mode.
  bxm_txn_fifo u_out (
    .ref_clk(ref_clk),
    .rst(rst),
    .cap(is_mem ? bxm_pkg::OUT_BUFS_MEM : bxm_pkg::OUT_BUFS_PROC),
    .push(loc_req_valid && ready_out_r),
    .din(loc_req),
    .full(out_full),
    .pop(out_pop),
    .head(out_head),
    .empty(out_empty),
    .count(out_cnt)
  );

  // Inbound buffer, served strictly in arrival order.
  bxm_txn_fifo u_in (
    .ref_clk(ref_clk),
    .rst(rst),
    .cap(is_mem ? bxm_pkg::IN_BUFS_MEM : bxm_pkg::IN_BUFS_PROC),
    .push(in_push),
    .din(sys_req),
    .full(in_full),
    .pop(in_pop),
    .head(in_head),
    .empty(in_empty),
    .count(in_cnt)
  );

  // Lock tracker, active in memory mode only.
  bxm_rmw_lock u_lock (
    .ref_clk(ref_clk),
    .rst(rst),
    .enable(is_mem),
    .set(lk_set),
    .clr(lk_clr),
    .addr(cur_r.addr),
    .query(in_head),
    .held(lk_held),
    .blocked(lk_block)
  );

  // Only requests inside the window, or messages, are taken from the system bus.
  assign in_push = sys_req_valid && ready_in_r
    && (in_window(sys_req.addr, match_r, mask_r) || is_msg(sys_req.addr));
  // Outbound goes first whenever both are waiting.
  assign out_pop = (state_r == ST_IDLE) && cap_done_r && !out_empty;
  assign in_pop = (state_r == ST_RPY) || (state_r == ST_MSG);
  // Locked read sets the lock when done; locked write releases it.
  assign lk_set = (state_r == ST_WAIT) && loc_done && cur_r.rmw && !cur_r.write;
  assign lk_clr = (state_r == ST_WAIT) && loc_done && cur_r.rmw && cur_r.write;

  // Ready flags registered; they look one push ahead so no entry is lost.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ready_in_r <= 1'b0;
      ready_out_r <= 1'b0;
    end
    else
    begin
      ready_in_r <= cap_done_r && (in_cnt + {1'b0, in_push} < bxm_pkg::IN_BUFS_PROC) && !in_full;
      ready_out_r <= cap_done_r && !is_mem
        && ({1'b0, out_cnt} + {2'b00, loc_req_valid && ready_out_r} < {1'b0, bxm_pkg::OUT_BUFS_PROC}) && !out_full;
    end
  end

  // Request engine: outbound issue, inbound local access, reply.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      rpy_r <= '0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (cap_done_r && out_empty && !in_empty && !lk_block)
          begin
            cur_r <= in_head;
            if (is_msg(in_head.addr))
            begin
              // A message reply carries no data, so no stale word or error leaks out.
              rpy_r <= '0;
              state_r <= ST_MSG;
            end
            else if (master_ok)
              state_r <= ST_ARB;
            else
            begin
              rpy_r <= '{data: 32'h0000_0000, err: 1'b1};
              state_r <= ST_RPY;
            end
          end
        end
        ST_ARB:
          if (loc_grant)
            state_r <= ST_WAIT;
        ST_WAIT:
          if (loc_done)
          begin
            rpy_r <= loc_rdata;
            state_r <= ST_RPY;
          end
        ST_MSG:
          state_r <= ST_IDLE;
        ST_RPY:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // Reply packets, one per inbound request, in order.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rpy_valid_r <= 1'b0;
      msg_r <= 1'b0;
      msg_addr_r <= 32'h0000_0000;
    end
    else
    begin
      rpy_valid_r <= in_pop;
      msg_r <= (state_r == ST_MSG) && !is_mem && ctl_r[bxm_pkg::CTL_MSG];
      if (state_r == ST_MSG)
        msg_addr_r <= cur_r.addr;
    end
  end

  // Local master access with the address unaltered, arbitration only as master.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      arb_r <= 1'b0;
      mst_valid_r <= 1'b0;
    end
    else
    begin
      arb_r <= (state_r == ST_IDLE && cap_done_r && out_empty && !in_empty && !lk_block
        && master_ok && !is_msg(in_head.addr)) || (state_r == ST_ARB && !loc_grant);
      mst_valid_r <= (state_r == ST_ARB) && loc_grant;
    end
  end

  // Outbound issue: plain read hits are served locally while the cache is on; all else goes out identically.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      out_valid_r <= 1'b0;
      out_r <= '0;
      lock_r <= 1'b0;
      cache_serve_r <= 1'b0;
    end
    else
    begin
      // Locked reads always go out, so the lock signal can mark them on the system bus.
      cache_serve_r <= out_pop && out_head.hit && en_r[bxm_pkg::CTL_CACHE] && !out_head.write
        && !out_head.rmw;
      out_valid_r <= out_pop && !(out_head.hit && en_r[bxm_pkg::CTL_CACHE] && !out_head.write && !out_head.rmw);
      if (out_pop)
      begin
        out_r <= out_head;
        lock_r <= out_head.rmw && !is_mem;
      end
      else
        lock_r <= 1'b0;
    end
  end

  // Function enables follow the mode; software can only narrow them.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      en_r <= 5'h00;
    else
    begin
      en_r[bxm_pkg::CTL_MODE] <= is_mem;
      en_r[bxm_pkg::CTL_GMEM] <= master_ok;
      en_r[bxm_pkg::CTL_CACHE] <= !is_mem && ctl_r[bxm_pkg::CTL_CACHE];
      en_r[bxm_pkg::CTL_PREF] <= !is_mem && ctl_r[bxm_pkg::CTL_PREF];
      en_r[bxm_pkg::CTL_MSG] <= !is_mem && ctl_r[bxm_pkg::CTL_MSG];
    end
  end

  // Dual-function pins. Processor: cache read, cache write, two message
  // lines. Memory: direction, data enable, error, fault, corrected,
  // memory-or-register, uncorrectable, ECC.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pins_r <= 8'h00;
    else if (is_mem)
      pins_r <= {mem_status[3], mem_status[2], !cur_r.addr[31], mem_status[1], mem_status[0],
        mem_status[0] || mem_status[2], state_r == ST_WAIT, cur_r.write};
    else
      pins_r <= {6'h00, out_pop && !out_head.write && en_r[bxm_pkg::CTL_CACHE],
        out_pop && out_head.write && en_r[bxm_pkg::CTL_CACHE]} | {4'h0, 2'b00, 2'b00}
        | {2'b00, msg_r, state_r == ST_MSG, 4'h0};
  end

  // Outputs straight from flip-flops.
  assign reg_rdata = reg_rdata_r;
  assign loc_req_ready = ready_out_r;
  assign loc_cache_serve = cache_serve_r;
  assign sys_out_valid = out_valid_r;
  assign sys_out = out_r;
  assign sys_lock = lock_r;
  assign sys_req_ready = ready_in_r;
  assign sys_rpy_valid = rpy_valid_r;
  assign sys_rpy = rpy_r;
  assign loc_arb_req = arb_r;
  assign loc_mst_valid = mst_valid_r;
  assign loc_mst = cur_r;
  assign inter_agent_message = msg_r;
  assign msg_addr = msg_addr_r;
  assign mode_mem = en_r[bxm_pkg::CTL_MODE];
  assign cache_en = en_r[bxm_pkg::CTL_CACHE];
  assign prefetch_en = en_r[bxm_pkg::CTL_PREF];
  assign msg_en = en_r[bxm_pkg::CTL_MSG];
  assign mem_sup_en = en_r[bxm_pkg::CTL_MODE];
  assign dual_pins = pins_r;
endmodule

// [bxm_pkg.sv]
// Shared constants and types for the bus extension mode control block.
package bxm_pkg;
  // Operating mode, captured from the strap at reset.
  localparam logic MODE_PROC = 1'b0;
  localparam logic MODE_MEM = 1'b1;
  localparam logic MODE_RST = MODE_PROC;
  // Transaction buffer counts per direction and mode.
  localparam int BUF_DEPTH = 3;
  localparam logic [1:0] IN_BUFS_PROC = 2'h3;
  localparam logic [1:0] OUT_BUFS_PROC = 2'h3;
  localparam logic [1:0] IN_BUFS_MEM = 2'h3;
  localparam logic [1:0] OUT_BUFS_MEM = 2'h0;
  // Register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MATCH = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  // Control register fields.
  localparam int CTL_MODE = 0;
  localparam int CTL_GMEM = 1;
  localparam int CTL_CACHE = 2;
  localparam int CTL_PREF = 3;
  localparam int CTL_MSG = 4;
  localparam int CTL_W = 5;
  localparam logic [CTL_W-1:0] CTL_RST = 5'h1C;
  // Status register fields.
  localparam int ST_IN = 0;
  localparam int ST_OUT = 2;
  localparam int ST_LOCK = 4;
  localparam int ST_BUSY = 5;
  // Address window reset values.
  localparam logic [31:0] MATCH_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  // Top byte of the message space.
  localparam logic [7:0] MSG_SPACE = 8'hFF;
  // One request packet.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic write;
    logic rmw;
    logic hit;
  } bxm_req_s;
  // One reply packet.
  typedef struct packed {
    logic [31:0] data;
    logic err;
  } bxm_rpy_s;
  localparam int REQ_W = $bits(bxm_req_s);
endpackage

// [bxm_txn_fifo.sv]
// Small in-order transaction buffer with a mode-dependent capacity.
`timescale 1ns/10ps
module bxm_txn_fifo (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Capacity in entries, zero disables the buffer.
  input wire logic [1:0] cap,
  // Fill side.
  input wire logic push,
  input wire bxm_pkg::bxm_req_s din,
  output logic full,
  // Drain side.
  input wire logic pop,
  output bxm_pkg::bxm_req_s head,
  output logic empty,
  output logic [1:0] count
);
  bxm_pkg::bxm_req_s mem_r [bxm_pkg::BUF_DEPTH];
  logic [1:0] rd_r;
  logic [1:0] wr_r;
  logic [1:0] cnt_r;

  // Full against the capacity, so a zero capacity takes nothing.
  assign full = (cnt_r >= cap);
  assign empty = (cnt_r == 2'h0);
  assign count = cnt_r;
  assign head = mem_r[rd_r];

  // Pointer and count update; a push into a full buffer is dropped.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_r <= 2'h0;
      wr_r <= 2'h0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push && !full)
        wr_r <= (wr_r == 2'h2) ? 2'h0 : wr_r + 2'h1;
      if (pop && !empty)
        rd_r <= (rd_r == 2'h2) ? 2'h0 : rd_r + 2'h1;
      cnt_r <= cnt_r + {1'b0, push && !full} - {1'b0, pop && !empty};
    end
  end

  // Storage carries no reset; entries are read only while counted.
  always_ff @(posedge ref_clk)
  begin
    if (push && !full)
      mem_r[wr_r] <= din;
  end
endmodule

// [bxm_rmw_lock.sv]
// Internal read-modify-write lock for inbound requests in memory mode.
`timescale 1ns/10ps
module bxm_rmw_lock (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Lock control.
  input wire logic enable,
  input wire logic set,
  input wire logic clr,
  input wire logic [31:0] addr,
  // Query for the next request.
  input wire bxm_pkg::bxm_req_s query,
  output logic held,
  output logic blocked
);
  logic held_r;
  logic [31:0] addr_r;

  assign held = held_r;
  // Only the closing locked write may touch a locked word.
  assign blocked = held_r && (query.addr == addr_r) && !(query.rmw && query.write);

  // Set on the locked read, release on the locked write.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      held_r <= 1'b0;
      addr_r <= 32'h0000_0000;
    end
    else if (!enable)
      held_r <= 1'b0;
    else if (set)
    begin
      held_r <= 1'b1;
      addr_r <= addr;
    end
    else if (clr)
      held_r <= 1'b0;
  end
endmodule

// [bxm_properties.sv]
// Port-level checker for the bus extension mode control block.
`timescale 1ns/10ps
module bxm_properties (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Watched ports.
  input wire logic loc_req_ready,
  input wire logic loc_cache_serve,
  input wire logic sys_out_valid,
  input wire bxm_pkg::bxm_req_s sys_out,
  input wire logic sys_lock,
  input wire logic sys_rpy_valid,
  input wire bxm_pkg::bxm_rpy_s sys_rpy,
  input wire logic loc_arb_req,
  input wire logic loc_mst_valid,
  input wire logic loc_done,
  input wire bxm_pkg::bxm_rpy_s loc_rdata,
  input wire logic inter_agent_message,
  input wire logic [3:0] mem_status,
  input wire logic mode_mem,
  input wire logic cache_en,
  input wire logic prefetch_en,
  input wire logic msg_en,
  input wire logic mem_sup_en,
  input wire logic [7:0] dual_pins
);
  logic [2:0] since_r;
  // Counts cycles after reset so that mode checks skip the capture window.
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      since_r <= 3'h0;
    else if (since_r != 3'h7)
      since_r <= since_r + 3'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A finished local access is answered two cycles later with its data.
  sequence s_reply;
    ##2 sys_rpy_valid && sys_rpy.data == $past(loc_rdata.data, 2);
  endsequence
  mode_hold_a: assert property (since_r == 3'h7 |-> $stable(mode_mem)) else $error("mode changed");
  mem_func_a: assert property (since_r == 3'h7 && mode_mem |-> !cache_en && !prefetch_en && !msg_en
    && mem_sup_en) else $error("memory mode enables wrong");
  proc_func_a: assert property (since_r == 3'h7 && !mode_mem |-> !mem_sup_en) else $error("memory support on");
  mem_slave_a: assert property (mode_mem |-> !loc_req_ready && !loc_cache_serve) else $error("local taken");
  mem_no_out_a: assert property (mode_mem |-> !sys_out_valid) else $error("outbound in memory mode");
  lock_mark_a: assert property (sys_out_valid |-> sys_lock == (sys_out.rmw && !mode_mem)) else $error("lock");
  lock_alone_a: assert property (sys_lock |-> sys_out_valid) else $error("stray lock");
  msg_proc_a: assert property (inter_agent_message |-> !mode_mem && msg_en) else $error("message");
  cache_serve_a: assert property (loc_cache_serve |-> cache_en && !mode_mem) else $error("cache serve");
  mst_granted_a: assert property ($rose(loc_mst_valid) |-> $past(loc_arb_req)) else $error("no arbitration");
  reply_data_a: assert property (loc_done |-> s_reply) else $error("reply missing");
  mem_pins_a: assert property (since_r == 3'h7 && mode_mem |-> dual_pins[7:6] == $past(mem_status[3:2])
    && dual_pins[4:3] == $past(mem_status[1:0])) else $error("memory pins");
  proc_pins_a: assert property (since_r == 3'h7 && !mode_mem |-> dual_pins[3:2] == 2'h0
    && dual_pins[7:6] == 2'h0) else $error("processor pins");
endmodule
bind bxm_mode_ctrl bxm_properties u_bxm_properties (.*);

// [bxm_local_model.sv]
// Behavioural local bus resident that answers the block's master cycles.
`timescale 1ns/10ps
module bxm_local_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Master side of the block.
  input wire logic loc_arb_req,
  input wire logic loc_mst_valid,
  input wire bxm_pkg::bxm_req_s loc_mst,
  output logic loc_grant,
  output logic loc_done,
  output bxm_pkg::bxm_rpy_s loc_rdata
);
  int wait_r;
  logic busy_r;
  logic [31:0] addr_r;
  // Grants after random pauses and ends each access up to four cycles later.
  // The data lines flip when idle so a stale word can never pass for an answer.
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      loc_grant <= 1'b0;
      loc_done <= 1'b0;
      busy_r <= 1'b0;
      wait_r <= 0;
      loc_rdata <= '0;
    end
    else
    begin
      loc_grant <= loc_arb_req && ($urandom_range(0, 2) != 0);
      loc_done <= 1'b0;
      loc_rdata.data <= ~loc_rdata.data;
      if (loc_mst_valid)
      begin
        busy_r <= 1'b1;
        addr_r <= loc_mst.addr;
        wait_r <= $urandom_range(0, 3);
      end
      else if (busy_r && wait_r != 0)
        wait_r <= wait_r - 1;
      else if (busy_r)
      begin
        busy_r <= 1'b0;
        loc_done <= 1'b1;
        loc_rdata <= {addr_r[15:0], addr_r[31:16], 1'b0};
      end
    end
  end
endmodule

// [bxm_mode_ctrl_tb_top.sv]
// Self-checking bench for the mode control block and its local bus model.
`timescale 1ns/10ps
module bxm_mode_ctrl_tb_top;
  logic ref_clk, rst, mode_strap_pin, reg_wr, reg_rd, loc_req_valid, loc_req_ready, loc_cache_serve;
  logic sys_out_valid, sys_lock, sys_req_valid, sys_req_ready, sys_rpy_valid, loc_arb_req, loc_grant;
  logic loc_mst_valid, loc_done, inter_agent_message, mode_mem, cache_en, prefetch_en, msg_en, mem_sup_en;
  logic [7:0] reg_addr, dual_pins;
  logic [31:0] reg_wdata, reg_rdata, msg_addr, rd, a;
  logic [3:0] mem_status;
  bxm_pkg::bxm_req_s loc_req, sys_out, sys_req, loc_mst;
  bxm_pkg::bxm_rpy_s sys_rpy, loc_rdata;
  logic [33:0] rq[$];
  logic [32:0] oq[$];
  logic [31:0] lq[$];
  int failures, num_checks, msg_cnt, srv_cnt, srv_exp;
  logic arb_seen;
  time t_out, t_mst;
  bxm_mode_ctrl u_bxm_mode_ctrl (.*);
  bxm_local_model u_bxm_local_model (.*);
  // Free-running system clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Cuts a hung run short.
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The local resident answers with the halves of the address swapped.
  function automatic logic [31:0] exp_data(input logic [31:0] x);
    return {x[15:0], x[31:16]};
  endfunction
  function automatic logic [31:0] rnd_addr();
    return $urandom & 32'h7FFF_FFFF;
  endfunction
  task automatic reg_write(input logic [7:0] ad, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] ad, output logic [31:0] d);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask
  task automatic in_req(input logic [31:0] x, input logic [1:0] kind, input logic [33:0] e, input logic to_loc);
    int n;
    n = 0;
    rq.push_back(e);
    if (to_loc)
      lq.push_back(x);
    sys_req_valid <= 1'b1;
    sys_req <= {x, $urandom, kind, 1'b0};
    do @(posedge ref_clk); while (!sys_req_ready && ++n < 100);
    sys_req_valid <= 1'b0;
  endtask
  // Kind is write, rmw, hit; a plain read that hits is served locally, all else goes out.
  task automatic out_req(input logic [31:0] x, input logic [2:0] kind);
    int n;
    n = 0;
    if (kind == 3'b001)
      srv_exp++;
    else
      oq.push_back({kind[1], x});
    loc_req_valid <= 1'b1;
    loc_req <= {x, $urandom, kind};
    do @(posedge ref_clk); while (!loc_req_ready && ++n < 100);
    loc_req_valid <= 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((rq.size() != 0 || oq.size() != 0 || lq.size() != 0) && n < 300)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(33'(n < 300), 33'h1);
  endtask
  task automatic do_reset(input logic strap);
    rst <= 1'b1;
    mode_strap_pin <= strap;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask
  // Compares replies, outbound issues and local accesses in order against the queues.
  always @(posedge ref_clk)
  begin
    // Any issue or reply with nothing awaited is a mismatch too.
    if (!rst && ((sys_rpy_valid && rq.size() == 0) || (sys_out_valid && oq.size() == 0)
      || (loc_mst_valid && lq.size() == 0)))
      chk(33'h0, 33'h1);
    if (!rst && sys_rpy_valid && rq.size() != 0)
    begin
      if (rq[0][33])
        chk(sys_rpy.data, rq[0][31:0]);
      chk(sys_rpy.err, rq.pop_front() >> 32 & 1);
    end
    if (!rst && sys_out_valid && oq.size() != 0)
    begin
      t_out = $time;
      chk({sys_lock, sys_out.addr}, oq.pop_front());
    end
    if (!rst && loc_mst_valid && lq.size() != 0)
    begin
      t_mst = $time;
      chk(loc_mst.addr, lq.pop_front());
    end
    if (loc_arb_req)
      arb_seen = 1'b1;
    if (loc_cache_serve)
      srv_cnt++;
    if (inter_agent_message)
    begin
      msg_cnt++;
      chk(msg_addr, a);
    end
  end
  // Main sequence: processor mode first, then memory mode after a second reset.
  initial
  begin
    {rst, mode_strap_pin, reg_wr, reg_rd, loc_req_valid, sys_req_valid} = 6'h20;
    {reg_addr, reg_wdata, mem_status, loc_req, sys_req} = '0;
    void'($urandom(32'h7223));
    do_reset(1'b0);
    reg_read(bxm_pkg::REG_CTRL, rd);
    chk(rd, bxm_pkg::CTL_RST);
    chk({cache_en, prefetch_en, msg_en, mem_sup_en}, 4'hE);
    mode_strap_pin <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(mode_mem, 1'b0);
    arb_seen = 1'b0;
    in_req(rnd_addr(), 2'b00, {2'b01, 32'h0}, 1'b0);
    drain();
    chk(arb_seen, 1'b0);
    reg_write(bxm_pkg::REG_CTRL, 32'h0000_001E);
    for (int i = 0; i < 8; i++)
    begin
      a = rnd_addr();
      in_req(a, 2'b00, {2'b10, exp_data(a)}, 1'b1);
      out_req(rnd_addr(), (i == 0) ? 3'b001 : 3'($urandom));
    end
    drain();
    fork
      in_req(rnd_addr(), 2'b00, {2'b00, 32'h0}, 1'b1);
      out_req(rnd_addr(), 3'($urandom) | 3'b010);
    join
    drain();
    chk(33'(t_out < t_mst), 33'h1);
    chk(srv_cnt, srv_exp);
    a = {8'hFF, 24'($urandom)};
    in_req(a, 2'b00, {2'b00, 32'h0}, 1'b0);
    drain();
    chk(msg_cnt, 1);
    do_reset(1'b1);
    reg_read(bxm_pkg::REG_CTRL, rd);
    chk(rd & 32'h1, 32'h1);
    chk({mode_mem, cache_en, prefetch_en, msg_en, mem_sup_en}, 5'h11);
    loc_req_valid <= 1'b1;
    repeat (10) @(posedge ref_clk) chk(loc_req_ready, 1'b0);
    loc_req_valid <= 1'b0;
    a = rnd_addr();
    in_req(a, 2'b01, {2'b10, exp_data(a)}, 1'b1);
    drain();
    reg_read(bxm_pkg::REG_STAT, rd);
    chk(rd[bxm_pkg::ST_LOCK], 1'b1);
    in_req(a, 2'b11, {2'b10, exp_data(a)}, 1'b1);
    drain();
    reg_read(bxm_pkg::REG_STAT, rd);
    chk(rd[bxm_pkg::ST_LOCK], 1'b0);
    reg_read(8'h40, rd);
    chk(rd, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      mem_status <= 4'($urandom);
      repeat (2) @(posedge ref_clk);
      chk({dual_pins[7:6], dual_pins[4:3]}, mem_status);
    end
    a = rnd_addr();
    in_req(a, 2'b00, {2'b10, exp_data(a)}, 1'b1);
    drain();
    complete_run();
  end
endmodule
